// File: pkg/selfid_fmt_pkg.sv
// Constants and types shared by the self-ID receive formatter.
package selfid_fmt_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the register bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] TOKEN_OFS = 8'h08;

	// Control register fields and reset values.
	localparam int CTRL_RX_EN_BIT = 0;
	localparam int CTRL_STORE_INV_BIT = 1;
	localparam logic CTRL_RX_EN_RST = 1'h0;
	localparam logic CTRL_STORE_INV_RST = 1'h0;

	// Status register fields.
	localparam int STATUS_DONE_BIT = 0;
	localparam int STATUS_FAULT_LSB = 4;
	localparam int STATUS_COUNT_LSB = 16;

	// ----------------------------------------------------------------
	// Token field values
	// ----------------------------------------------------------------
	localparam logic [2:0] FAULT_NONE = 3'h0;
	localparam logic [2:0] FAULT_NOT_INVERSE = 3'h7;
	localparam logic [1:0] SPEED_100 = 2'h0;
	localparam logic [1:0] SPEED_200 = 2'h1;
	localparam logic [1:0] SPEED_400 = 2'h2;
	localparam logic [3:0] PAD_NONE = 4'h0;
	localparam int COUNT_W = 14;

	// Packet control token, most significant field first.
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [COUNT_W-1:0] token_quadlet_count;
		logic selfid_flag;
		logic phy_packet_flag;
		logic rsvd_mid;
		logic [2:0] selfid_fault_field;
		logic [3:0] fill_byte_count;
		logic [1:0] speed_code;
		logic [3:0] rsvd_lo;
	} token_type;

	localparam logic [31:0] TOKEN_RST = 32'h0000_0000;

	// One write into the data buffer: location and word.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
	} buf_entry_type;

	// First buffer location after a bus reset holds the token.
	localparam logic [7:0] TOKEN_ADDR = 8'h00;
	localparam logic [7:0] FIRST_DATA_ADDR = 8'h01;

endpackage : selfid_fmt_pkg

// File: rtl/selfid_receive_formatter.sv
// Self-ID receive formatter: stores self-ID quadlets behind a packet control token.
`timescale 1ns/1ns

// Behaviour
// - Store-inverse off: store only each data quadlet plus token; drop inverses.
// - Every stored self-ID group carries a packet control token, in both modes.
// - Token quadlet count equals number of stored quadlets.
// - Token self-ID flag is 1 when token accompanies self-ID data.
// - Token PHY-packet flag is 1 when token accompanies a PHY packet.
// - Token holds three-bit fault code, same encoding as link control fault field.
// - Token fill-byte count reports padding bytes appended.
// - Speed field 00/01/10 for 100/200/400 Mbps; 11 never produced.
// - Store-inverse on: each self-ID quadlet directly followed by its inverse.
// - After bus reset the token occupies the first buffer location.
// - Receive enable 0 at the bus reset means no self-ID packet is stored in that period.
// - Fault 111 when quadlet is not inverse of previous; 000 means none.
// - Set a done flag when the self-ID period has completed.
module selfid_receive_formatter #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Classic Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Quadlet stream from the link receiver, same clock
	input wire logic BUS_RESET,
	input wire logic PERIOD_END,
	input wire logic PHY_PKT_MODE,
	input wire logic QUAD_VALID,
	input wire logic [31:0] QUAD_DATA,
	input wire logic [1:0] QUAD_SPEED,
	output logic QUAD_READY,
	// Write port into the selected data buffer
	output logic BUF_VALID,
	output logic [ADDR_W-1:0] BUF_ADDR,
	output logic [31:0] BUF_DATA,
	input wire logic BUF_READY
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IDLE,
		DATA_Q,
		INV_Q,
		TOKEN_Q
	} state_type;

	// Increments sized to their registers, so no sum is wider than its target.
	localparam logic [ADDR_W-1:0] ADDR_STEP = ADDR_W'(1);
	localparam logic [selfid_fmt_pkg::COUNT_W-1:0] COUNT_STEP = {{(selfid_fmt_pkg::COUNT_W-1){1'b0}}, 1'b1};

	state_type state_q;
	logic rx_en_q;
	logic store_inv_q;
	logic done_q;
	logic [2:0] fault_q;
	logic [1:0] speed_q;
	logic phy_pkt_q;
	logic [selfid_fmt_pkg::COUNT_W-1:0] count_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [31:0] prev_q;
	logic [31:0] last_token_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic out_valid_q;
	selfid_fmt_pkg::buf_entry_type out_q;
	logic spare_valid_q;
	selfid_fmt_pkg::buf_entry_type spare_q;

	logic bus_write;
	logic bus_access;
	logic quad_take;
	logic store_quad;
	logic push;
	logic pop;
	logic inv_mismatch;
	logic [1:0] speed_ok;
	selfid_fmt_pkg::buf_entry_type push_entry;
	logic ctrl_write;
	logic done_clear;
	selfid_fmt_pkg::token_type token;

	// Replaces the undefined speed code so that 11 never reaches the token.
	function automatic logic [1:0] legal_speed(input logic [1:0] code);
		legal_speed = (code == 2'h3) ? selfid_fmt_pkg::SPEED_100 : code;
	endfunction : legal_speed

	// Decodes a write that reaches byte lane 0 of one register; both writable registers use it.
	function automatic logic lane0_hit(input logic [7:0] adr, input logic [3:0] sel, input logic [7:0] ofs);
		lane0_hit = sel[0] && adr == ofs;
	endfunction : lane0_hit

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// The answer comes one cycle after the request; a write takes effect
	// on the edge that the master sees ack high.
	assign bus_access = WB_CYC_I && WB_STB_I;
	assign bus_write = bus_access && WB_WE_I && ack_q;
	assign ctrl_write = bus_write && lane0_hit(WB_ADR_I, WB_SEL_I, selfid_fmt_pkg::CTRL_OFS);
	assign done_clear = bus_write && lane0_hit(WB_ADR_I, WB_SEL_I, selfid_fmt_pkg::STATUS_OFS)
		&& WB_DAT_I[selfid_fmt_pkg::STATUS_DONE_BIT];

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_access && !ack_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_access && !ack_q) begin
			unique case (WB_ADR_I)
				selfid_fmt_pkg::CTRL_OFS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[selfid_fmt_pkg::CTRL_RX_EN_BIT] <= rx_en_q;
					rdata_q[selfid_fmt_pkg::CTRL_STORE_INV_BIT] <= store_inv_q;
				end
				selfid_fmt_pkg::STATUS_OFS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[selfid_fmt_pkg::STATUS_DONE_BIT] <= done_q;
					rdata_q[selfid_fmt_pkg::STATUS_FAULT_LSB +: 3] <= fault_q;
					rdata_q[selfid_fmt_pkg::STATUS_COUNT_LSB +: selfid_fmt_pkg::COUNT_W] <= count_q;
				end
				selfid_fmt_pkg::TOKEN_OFS: begin
					rdata_q <= last_token_q;
				end
				default: begin
					rdata_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Control bits live in byte lane 0.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rx_en_q <= selfid_fmt_pkg::CTRL_RX_EN_RST;
			store_inv_q <= selfid_fmt_pkg::CTRL_STORE_INV_RST;
		end else if (ctrl_write) begin
			rx_en_q <= WB_DAT_I[selfid_fmt_pkg::CTRL_RX_EN_BIT];
			store_inv_q <= WB_DAT_I[selfid_fmt_pkg::CTRL_STORE_INV_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Quadlet intake
	// ----------------------------------------------------------------
	// A quadlet that arrives with a bus reset belongs to no period and is dropped.
	assign quad_take = QUAD_VALID && QUAD_READY && !BUS_RESET && (state_q == DATA_Q || state_q == INV_Q);
	// Inverse quadlets are checked in both modes but stored only in full mode.
	assign store_quad = quad_take && (state_q == DATA_Q || store_inv_q);
	assign inv_mismatch = quad_take && state_q == INV_Q && QUAD_DATA != ~prev_q;
	assign speed_ok = legal_speed(QUAD_SPEED);

	// ----------------------------------------------------------------
	// Token assembly
	// ----------------------------------------------------------------
	// The token goes out last but to location zero, so its count is already final.
	always_comb begin
		token = '0;
		token.token_quadlet_count = count_q;
		token.selfid_flag = !phy_pkt_q;
		token.phy_packet_flag = phy_pkt_q;
		token.selfid_fault_field = fault_q;
		token.fill_byte_count = selfid_fmt_pkg::PAD_NONE;
		token.speed_code = speed_q;
	end

	always_comb begin
		push = 1'b0;
		push_entry = '0;
		if (store_quad) begin
			push = 1'b1;
			push_entry.addr = 8'(wr_addr_q);
			push_entry.data = QUAD_DATA;
		end else if (state_q == TOKEN_Q && !spare_valid_q) begin
			push = 1'b1;
			push_entry.addr = selfid_fmt_pkg::TOKEN_ADDR;
			push_entry.data = token;
		end
	end

	// ----------------------------------------------------------------
	// Sequence control
	// ----------------------------------------------------------------
	// IDLE covers a disabled receiver and a finished period; only a bus reset leaves it.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_q <= IDLE;
		end else if (BUS_RESET) begin
			state_q <= rx_en_q ? DATA_Q : IDLE;
		end else begin
			unique case (state_q)
				IDLE: begin
					state_q <= IDLE;
				end
				DATA_Q: begin
					if (PERIOD_END) begin
						state_q <= TOKEN_Q;
					end else if (quad_take) begin
						state_q <= INV_Q;
					end
				end
				INV_Q: begin
					if (PERIOD_END) begin
						state_q <= TOKEN_Q;
					end else if (quad_take) begin
						state_q <= DATA_Q;
					end
				end
				TOKEN_Q: begin
					if (push) begin
						state_q <= IDLE;
					end
				end
			endcase
		end
	end

	// Consecutive locations after the token, in arrival order.
	always_ff @(posedge CLK) begin
		if (!NRST || BUS_RESET) begin
			wr_addr_q <= ADDR_W'(selfid_fmt_pkg::FIRST_DATA_ADDR);
			count_q <= '0;
		end else if (store_quad) begin
			wr_addr_q <= wr_addr_q + ADDR_STEP;
			count_q <= count_q + COUNT_STEP;
		end
	end

	// Holds the last data quadlet for the inverse check that follows it.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			prev_q <= 32'h0000_0000;
		end else if (quad_take && state_q == DATA_Q) begin
			prev_q <= QUAD_DATA;
		end
	end

	// The first fault seen in a period is kept.
	always_ff @(posedge CLK) begin
		if (!NRST || BUS_RESET) begin
			fault_q <= selfid_fmt_pkg::FAULT_NONE;
		end else if (inv_mismatch && fault_q == selfid_fmt_pkg::FAULT_NONE) begin
			fault_q <= selfid_fmt_pkg::FAULT_NOT_INVERSE;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			speed_q <= selfid_fmt_pkg::SPEED_100;
			phy_pkt_q <= 1'b0;
		end else if (BUS_RESET) begin
			speed_q <= selfid_fmt_pkg::SPEED_100;
			phy_pkt_q <= PHY_PKT_MODE;
		end else if (quad_take) begin
			speed_q <= speed_ok;
		end
	end

	// Done is set by the token write; set wins over a software clear.
	always_ff @(posedge CLK) begin
		if (!NRST || BUS_RESET) begin
			done_q <= 1'b0;
		end else if (state_q == TOKEN_Q && push) begin
			done_q <= 1'b1;
		end else if (done_clear) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			last_token_q <= selfid_fmt_pkg::TOKEN_RST;
		end else if (state_q == TOKEN_Q && push) begin
			last_token_q <= token;
		end
	end

	// ----------------------------------------------------------------
	// Two-entry output buffer
	// ----------------------------------------------------------------
	// A stalled buffer port fills the spare entry, which drops QUAD_READY,
	// so the receiver is held off instead of losing a quadlet.
	assign pop = out_valid_q && BUF_READY;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			out_valid_q <= 1'b0;
			out_q <= '0;
			spare_valid_q <= 1'b0;
			spare_q <= '0;
		end else if (!out_valid_q || pop) begin
			if (spare_valid_q) begin
				out_valid_q <= 1'b1;
				out_q <= spare_q;
				spare_valid_q <= push;
				spare_q <= push_entry;
			end else begin
				out_valid_q <= push;
				out_q <= push_entry;
			end
		end else if (push) begin
			spare_valid_q <= 1'b1;
			spare_q <= push_entry;
		end
	end

	// Ready is registered but looks ahead: it drops on the same edge that fills the spare entry.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			QUAD_READY <= 1'b1;
		end else begin
			QUAD_READY <= !(spare_valid_q || (out_valid_q && !BUF_READY && push));
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a register copy, so no port carries combinational logic.
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;
	assign BUF_VALID = out_valid_q;
	assign BUF_ADDR = ADDR_W'(out_q.addr);
	assign BUF_DATA = out_q.data;

endmodule : selfid_receive_formatter

// File: test/selfid_fmt_properties.sv
// Port-level assertions for the self-ID receive formatter.
`timescale 1ns/1ns
module selfid_fmt_checks #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	// Period control
	input wire logic BUS_RESET,
	// Buffer write port
	input wire logic BUF_VALID,
	input wire logic [ADDR_W-1:0] BUF_ADDR,
	input wire logic [31:0] BUF_DATA,
	input wire logic BUF_READY
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	logic tok;
	logic [13:0] cnt_q;
	assign tok = BUF_VALID && BUF_ADDR == '0;
	// Counts accepted data writes since the bus reset, so the token count is checked independently.
	always_ff @(posedge CLK) begin
		if (!NRST || BUS_RESET) begin
			cnt_q <= 14'h0000;
		end else if (BUF_VALID && BUF_READY && !tok) begin
			cnt_q <= cnt_q + 14'h0001;
		end
	end
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("bus request not acknowledged next cycle");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_buf_hold: assert property (BUF_VALID && !BUF_READY |=> BUF_VALID && $stable(BUF_ADDR) && $stable(BUF_DATA))
		else $error("buffer write changed while stalled");
	a_addr_step: assert property ((BUF_VALID && BUF_READY && !tok) ##1 (BUF_VALID && BUF_ADDR > 1)
		|-> BUF_ADDR == $past(BUF_ADDR) + ADDR_W'(1)) else $error("buffer address not consecutive");
	a_token_count: assert property (tok |-> BUF_DATA[29:16] == cnt_q)
		else $error("token count differs from stored quadlets");
	a_token_flags: assert property (tok |-> BUF_DATA[15] != BUF_DATA[14])
		else $error("token flags not exclusive");
	a_token_fault: assert property (tok |-> BUF_DATA[12:10] inside {3'h0, 3'h7})
		else $error("token fault code not produced by this block");
	a_token_fields: assert property (tok |-> BUF_DATA[5:4] != 2'h3 && BUF_DATA[9:6] == 4'h0)
		else $error("token speed or pad field wrong");
endmodule : selfid_fmt_checks

bind selfid_receive_formatter selfid_fmt_checks #(.ADDR_W(ADDR_W)) checks (.CLK(CLK), .NRST(NRST),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .BUS_RESET(BUS_RESET),
	.BUF_VALID(BUF_VALID), .BUF_ADDR(BUF_ADDR), .BUF_DATA(BUF_DATA), .BUF_READY(BUF_READY));

// File: test/phy_selfid_source.sv
// Behavioural cable PHY that sends self-ID packets as data and inverse quadlets.
`timescale 1ns/1ns
module phy_selfid_source (
	// Clock
	input wire logic CLK,
	// Quadlet stream
	output logic QUAD_VALID,
	output logic [31:0] QUAD_DATA,
	output logic [1:0] QUAD_SPEED,
	input wire logic QUAD_READY
);
	logic [31:0] word = 32'h0000_0000, noise = 32'h0000_0000;
	// Set when the receiver did not take a quadlet within 64 cycles; the bench turns it into a failure.
	logic stuck = 1'h0;
	initial QUAD_VALID = 1'h0;
	initial QUAD_SPEED = 2'h0;
	// Idle data toggles every cycle so a stale word can never pass for a fresh one.
	always @(posedge CLK) noise <= ~noise;
	assign QUAD_DATA = QUAD_VALID ? word : noise;
	task automatic send(input logic [31:0] q, input logic bad, input logic [1:0] spd, input int gap);
		int i, k;
		for (i = 0; i < 2; i++) begin
			repeat (gap) @(posedge CLK);
			word <= (i == 0 || bad) ? q : ~q;
			QUAD_SPEED <= spd;
			QUAD_VALID <= 1'h1;
			@(posedge CLK);
			for (k = 0; k < 64 && QUAD_READY !== 1'h1; k++) @(posedge CLK);
			if (k == 64) stuck = 1'h1;
			QUAD_VALID <= 1'h0;
		end
	endtask : send
endmodule : phy_selfid_source

// File: test/tb.sv
// Self-checking bench for the self-ID receive formatter.
`timescale 1ns/1ns
module tb;
	logic clk, ack, q_valid, q_ready, b_valid;
	logic nrst = 1'h0, wb_req = 1'h0, wb_we = 1'h0, bus_reset = 1'h0, period_end = 1'h0;
	logic phy_mode = 1'h0, b_ready = 1'h1, stall = 1'h0;
	logic [7:0] wb_adr = 8'h00, b_addr;
	logic [31:0] wb_dat = 32'h0, rnd = 32'h0001_039C, rd_dat, wb_q, q_data, b_data;
	logic [1:0] q_speed;
	selfid_fmt_pkg::buf_entry_type exp_q[$];
	int mismatches, samples_checked, refused;
	selfid_receive_formatter dut (.CLK(clk), .NRST(nrst), .WB_CYC_I(wb_req), .WB_STB_I(wb_req),
		.WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(4'hF), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_q),
		.WB_ACK_O(ack), .BUS_RESET(bus_reset), .PERIOD_END(period_end), .PHY_PKT_MODE(phy_mode),
		.QUAD_VALID(q_valid), .QUAD_DATA(q_data), .QUAD_SPEED(q_speed), .QUAD_READY(q_ready),
		.BUF_VALID(b_valid), .BUF_ADDR(b_addr), .BUF_DATA(b_data), .BUF_READY(b_ready));
	phy_selfid_source src (.CLK(clk), .QUAD_VALID(q_valid), .QUAD_DATA(q_data), .QUAD_SPEED(q_speed),
		.QUAD_READY(q_ready));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk);
		wb_req <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		for (k = 0; k < 9; k++) begin
			@(posedge clk);
			if (ack === 1'h1) break;
		end
		if (k == 9) begin
			mismatches++;
			test_done();
		end
		q = wb_q;
		wb_req <= 1'h0;
	endtask : wb
	// The sink stalls at random while asked to, which fills the two-entry buffer.
	always @(posedge clk) begin
		rnd <= xs(rnd);
		b_ready <= stall ? rnd[3] & rnd[7] : 1'h1;
		if (q_ready === 1'h0) refused++;
		if (nrst && b_valid === 1'h1 && b_ready === 1'h1) begin
			if (exp_q.size() == 0) check({b_addr, b_data}, ~{b_addr, b_data});
			else check({b_addr, b_data}, exp_q.pop_front());
		end
	end
	task automatic period(input logic en, full, phy, input logic [1:0] spd, input int n, bad);
		selfid_fmt_pkg::token_type t;
		logic [31:0] q;
		logic [7:0] a;
		int i, k;
		wb(1'h1, selfid_fmt_pkg::CTRL_OFS, {30'h0, full, en}, rd_dat);
		phy_mode <= phy;
		bus_reset <= 1'h1;
		@(posedge clk);
		bus_reset <= 1'h0;
		a = selfid_fmt_pkg::FIRST_DATA_ADDR;
		for (i = 1; i <= n; i++) begin
			q = rnd;
			if (en) exp_q.push_back({a, q});
			if (en) a++;
			if (en && full) exp_q.push_back({a, ~q});
			if (en && full) a++;
			src.send(q, bad != 0 && i == n, spd, 1 + int'(rnd[1:0]));
			if (src.stuck) begin
				mismatches++;
				test_done();
			end
		end
		t = '0;
		t.token_quadlet_count = 14'(a - 8'h01);
		t.selfid_flag = !phy;
		t.phy_packet_flag = phy;
		t.selfid_fault_field = bad != 0 ? selfid_fmt_pkg::FAULT_NOT_INVERSE : selfid_fmt_pkg::FAULT_NONE;
		t.fill_byte_count = selfid_fmt_pkg::PAD_NONE;
		t.speed_code = spd == 2'h3 ? selfid_fmt_pkg::SPEED_100 : spd;
		if (en) exp_q.push_back({selfid_fmt_pkg::TOKEN_ADDR, t});
		@(posedge clk);
		period_end <= 1'h1;
		@(posedge clk);
		period_end <= 1'h0;
		for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge clk);
		repeat (8) @(posedge clk);
		check({8'h00, 32'(exp_q.size())}, 40'h0);
		if (exp_q.size() != 0) test_done();
		if (!en) return;
		wb(1'h0, selfid_fmt_pkg::STATUS_OFS, 32'h0, rd_dat);
		check({8'h00, rd_dat}, {10'h0, t.token_quadlet_count, 9'h0, t.selfid_fault_field, 4'h1});
		wb(1'h0, selfid_fmt_pkg::TOKEN_OFS, 32'h0, rd_dat);
		check({8'h00, rd_dat}, {8'h00, t});
		wb(1'h1, selfid_fmt_pkg::STATUS_OFS, 32'h1, rd_dat);
		wb(1'h0, selfid_fmt_pkg::STATUS_OFS, 32'h0, rd_dat);
		check({39'h0, rd_dat[0]}, 40'h0);
	endtask : period
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		wb(1'h0, selfid_fmt_pkg::CTRL_OFS, 32'h0, rd_dat);
		check({8'h00, rd_dat}, 40'h0);
		wb(1'h0, 8'h0C, 32'h0, rd_dat);
		check({8'h00, rd_dat}, 40'h0);
		period(1'h0, 1'h1, 1'h0, selfid_fmt_pkg::SPEED_100, 3, 0);
		period(1'h1, 1'h1, 1'h0, selfid_fmt_pkg::SPEED_100, 3, 0);
		stall <= 1'h1;
		// Self-ID periods stay at the base rate; only PHY packets exercise other speed codes, 400 and the undefined 11, never 200.
		period(1'h1, 1'h0, 1'h0, selfid_fmt_pkg::SPEED_100, 2, 1);
		period(1'h1, 1'h1, 1'h1, selfid_fmt_pkg::SPEED_400, 1, 0);
		period(1'h1, 1'h1, 1'h1, 2'h3, 3, 0);
		check({39'h0, refused != 0}, 40'h1);
		test_done();
	end
endmodule : tb
